/* File: logic/fbhome_regs.vh */
// Purpose: register map, reset values and codes for the load-side homing block
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: definitions only
`ifndef FBHOME_REGS_VH
`define FBHOME_REGS_VH
`define CTRL_OFS 8'h00
`define FILT_OFS 8'h04
`define LCUM_OFS 8'h08
`define LPOS_OFS 8'h0C
`define MCUM_OFS 8'h10
`define NUMA_OFS 8'h14
`define NUMB_OFS 8'h18
`define DENA_OFS 8'h1C
`define DENB_OFS 8'h20
`define MGEAR_OFS 8'h24
`define SHLO_OFS 8'h28
`define SHHI_OFS 8'h2C
`define REV_OFS 8'h30
`define HPOS_OFS 8'h34
`define STAT_OFS 8'h38
`define MASK_OFS 8'h3C
`define STATE_OFS 8'h40
`define CTRL_START_BIT 0
`define CTRL_TYPE_LSB 1
`define CTRL_DOG_BIT 3
`define CTRL_NOREF_BIT 4
`define CTRL_DIR_BIT 5
`define ST_DONE_BIT 0
`define ST_ERR_BIT 1
`define ST_REF_BIT 2
`define FILT_RST 13'h000A
`define FILT_MIN 13'h0001
`define FILT_DUAL_MAX 13'h1193
`define FILT_FULL 13'h1194
`define GEAR_RST 16'h0001
`define REV_RST 32'h00001000
`define ENC_ABS 2'h0
`define ENC_INC 2'h1
`define ENC_ROT 2'h2
`endif

/* File: logic/sync_stage.v */
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to CLK_IN
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module sync_stage #(
	parameter WIDTH = 1
) (
	input wire clk_in, // block clock
	input wire rst_n_in, // synchronous reset, active low
	input wire [WIDTH-1:0] async_in, // raw pin levels
	output reg [WIDTH-1:0] sync_out // levels safe to use
);
	reg [WIDTH-1:0] meta_reg; // first stage, read by sync_out only

	// two stages against metastability
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // sync_stage

/* File: logic/fb_home.v */
// Purpose: load-side feedback counting, filter mode select and homing
// Assumes: encoder delivers up/down step strobes and a reference mark level
// Notes: classic Wishbone slave, one wait state on every access
`timescale 1ns/1ns
`include "fbhome_regs.vh"
// Contract
// (R1) clear load position counter at reference mark
// (R2) count load-side pulses, driven or not
// (R3) filter 1..4499 dual, 4500 fully closed
// (R4) filter setting resets to ten
// (R5) user keeps filter below half loop gain
// (R6) homing uses only load-side data
// (R7) setup crosses reference before dog off
// (R8) absolute: grid per revolution from zero
// (R9) absolute dog homing: nearest grid after off
// (R10) incremental: grid from first crossed mark
// (R11) home is nearest grid plus shift
// (R12) no reference mark: only non-Z homing; code refuses dog homing with noref for the incremental type only
// (R13) controller jogs to opposite end first
// (R14) geared motor count tracks load count
// (R15) user picks 4096..67108864 pulses per rev
// (R16) flag error when dog homing saw no mark
module fb_home (
	input wire CLK_IN, // 100 MHz clock
	input wire RST_N_IN, // synchronous reset, active low
	input wire WB_CYC_IN, // wishbone cycle
	input wire WB_STB_IN, // wishbone strobe
	input wire WB_WE_IN, // wishbone write enable
	input wire [7:0] WB_ADR_IN, // byte address
	input wire [3:0] WB_SEL_IN, // byte lanes
	input wire [31:0] WB_DAT_IN, // write data
	output reg [31:0] WB_DAT_OUT, // read data
	output reg WB_ACK_OUT, // acknowledge
	input wire LOAD_UP_IN, // load encoder step forward
	input wire LOAD_DN_IN, // load encoder step back
	input wire LOAD_REF_IN, // load reference mark or z phase
	input wire MOTOR_UP_IN, // motor encoder step forward
	input wire MOTOR_DN_IN, // motor encoder step back
	input wire DOG_IN, // proximity dog
	output reg DUAL_FB_OUT, // dual feedback mode
	output reg FULL_CLOSED_OUT, // pure fully closed mode
	output wire HOMING_OUT, // homing in progress
	output reg HOME_VALID_OUT, // home position established
	output wire IRQ_OUT // level interrupt
);
	localparam S_IDLE = 2'h0; // waiting for start
	localparam S_DOGON = 2'h1; // waiting for dog on
	localparam S_DOGOFF = 2'h2; // waiting for dog off

	wire [5:0] pins; // synchronised pins
	reg [5:0] pins_d_reg; // previous pin levels
	wire l_up, l_dn, l_ref, m_up, m_dn, dog; // rising edges and dog level
	reg ack_reg; // ack flop
	reg [5:0] ctrl_reg; // start/type/dog/noref/dir
	reg [12:0] filt_reg; // dual feedback filter setting
	reg [31:0] lcum_reg; // load cumulative pulses
	reg [31:0] lpos_reg; // load position information
	reg [31:0] mcum_reg; // motor pulses before gear
	reg [31:0] mgear_reg; // motor pulses after gear
	reg signed [47:0] resid_reg; // gear remainder
	reg [15:0] numa_reg, numb_reg, dena_reg, denb_reg; // gear terms
	reg [15:0] shlo_reg, shhi_reg; // home shift distance halves
	reg [31:0] rev_reg; // load pulses per motor revolution
	reg [31:0] phase_reg; // offset inside current revolution
	reg [31:0] hpos_reg; // resulting home position
	reg [2:0] stat_reg; // sticky events
	reg [2:0] mask_reg; // interrupt enables
	reg [1:0] state_reg; // homing state
	reg ref_seen_reg; // mark crossed since start
	reg [2:0] ev_set; // events this cycle
	wire wr, rd_go; // bus write taken, read prepared
	wire [31:0] gnum, gden; // gear numerator and denominator
	wire [31:0] shift; // joined shift distance
	wire [31:0] ahead; // pulses to next grid point forward
	wire [31:0] grid_pt; // nearest grid point past dog off
	wire start; // software start request
	wire [1:0] enc_type; // load encoder kind

	sync_stage #(.WIDTH(6)) u_sync (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.async_in({DOG_IN, MOTOR_DN_IN, MOTOR_UP_IN, LOAD_REF_IN, LOAD_DN_IN, LOAD_UP_IN}),
		.sync_out(pins)
	);

	// edge history on synchronised levels only
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			pins_d_reg <= 6'h00;
		end else begin
			pins_d_reg <= pins;
		end
	end

	assign l_up = pins[0] & ~pins_d_reg[0];
	assign l_dn = pins[1] & ~pins_d_reg[1];
	assign l_ref = pins[2] & ~pins_d_reg[2];
	assign m_up = pins[3] & ~pins_d_reg[3];
	assign m_dn = pins[4] & ~pins_d_reg[4];
	assign dog = pins[5];

	// bus: ack one cycle after strobe, write lands at the acked edge
	assign wr = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ack_reg;
	assign rd_go = WB_CYC_IN & WB_STB_IN & ~ack_reg;
	assign start = wr && (WB_ADR_IN == `CTRL_OFS) && WB_SEL_IN[0] && WB_DAT_IN[`CTRL_START_BIT];
	assign enc_type = ctrl_reg[`CTRL_TYPE_LSB+1:`CTRL_TYPE_LSB];
	assign gnum = numa_reg * numb_reg;
	assign gden = dena_reg * denb_reg;
	assign shift = {shhi_reg, shlo_reg};
	assign ahead = (phase_reg == 32'h00000000) ? 32'h00000000 : rev_reg - phase_reg;
	// grid point reached next in the travel direction
	assign grid_pt = ctrl_reg[`CTRL_DIR_BIT] ? lcum_reg - phase_reg : lcum_reg + ahead; // R9
	assign HOMING_OUT = (state_reg != S_IDLE);
	assign IRQ_OUT = |(stat_reg & mask_reg);

	// ack flop, drops the cycle after it rose
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= WB_CYC_IN & WB_STB_IN & ~ack_reg;
		end
	end

	always @* WB_ACK_OUT = ack_reg; // port copy of the ack flop

	// read data loaded at the same edge that raises ack; unmapped reads zero
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			WB_DAT_OUT <= 32'h00000000;
		end else if (rd_go) begin
			if (WB_ADR_IN == `CTRL_OFS) begin
				WB_DAT_OUT <= {26'h0000000, ctrl_reg};
			end else if (WB_ADR_IN == `FILT_OFS) begin
				WB_DAT_OUT <= {19'h00000, filt_reg};
			end else if (WB_ADR_IN == `LCUM_OFS) begin
				WB_DAT_OUT <= lcum_reg;
			end else if (WB_ADR_IN == `LPOS_OFS) begin
				WB_DAT_OUT <= lpos_reg;
			end else if (WB_ADR_IN == `MCUM_OFS) begin
				WB_DAT_OUT <= mcum_reg;
			end else if (WB_ADR_IN == `NUMA_OFS) begin
				WB_DAT_OUT <= {16'h0000, numa_reg};
			end else if (WB_ADR_IN == `NUMB_OFS) begin
				WB_DAT_OUT <= {16'h0000, numb_reg};
			end else if (WB_ADR_IN == `DENA_OFS) begin
				WB_DAT_OUT <= {16'h0000, dena_reg};
			end else if (WB_ADR_IN == `DENB_OFS) begin
				WB_DAT_OUT <= {16'h0000, denb_reg};
			end else if (WB_ADR_IN == `MGEAR_OFS) begin
				WB_DAT_OUT <= mgear_reg;
			end else if (WB_ADR_IN == `SHLO_OFS) begin
				WB_DAT_OUT <= {16'h0000, shlo_reg};
			end else if (WB_ADR_IN == `SHHI_OFS) begin
				WB_DAT_OUT <= {16'h0000, shhi_reg};
			end else if (WB_ADR_IN == `REV_OFS) begin
				WB_DAT_OUT <= rev_reg;
			end else if (WB_ADR_IN == `HPOS_OFS) begin
				WB_DAT_OUT <= hpos_reg;
			end else if (WB_ADR_IN == `STAT_OFS) begin
				WB_DAT_OUT <= {29'h00000000, stat_reg};
			end else if (WB_ADR_IN == `MASK_OFS) begin
				WB_DAT_OUT <= {29'h00000000, mask_reg};
			end else if (WB_ADR_IN == `STATE_OFS) begin
				WB_DAT_OUT <= {29'h00000000, ref_seen_reg, state_reg};
			end else begin
				WB_DAT_OUT <= 32'h00000000; // unmapped
			end
		end
	end

	// configuration registers
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			ctrl_reg <= 6'h00;
			filt_reg <= `FILT_RST; // R4
			numa_reg <= `GEAR_RST;
			numb_reg <= `GEAR_RST;
			dena_reg <= `GEAR_RST;
			denb_reg <= `GEAR_RST;
			shlo_reg <= 16'h0000;
			shhi_reg <= 16'h0000;
			rev_reg <= `REV_RST;
			mask_reg <= 3'h0;
		end else if (wr) begin
			if (WB_ADR_IN == `CTRL_OFS) begin
				// start bit is a strobe, never stored
				if (WB_SEL_IN[0]) begin
					ctrl_reg <= {WB_DAT_IN[5:1], 1'b0};
				end
			end else if (WB_ADR_IN == `FILT_OFS) begin
				// out-of-range settings are refused, old value kept
				if (WB_SEL_IN[1:0] == 2'h3 && WB_DAT_IN[31:13] == 19'h00000 &&
					WB_DAT_IN[12:0] >= `FILT_MIN && WB_DAT_IN[12:0] <= `FILT_FULL) begin
					filt_reg <= WB_DAT_IN[12:0];
				end
			end else if (WB_ADR_IN == `NUMA_OFS) begin
				numa_reg <= {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : numa_reg[15:8],
					WB_SEL_IN[0] ? WB_DAT_IN[7:0] : numa_reg[7:0]};
			end else if (WB_ADR_IN == `NUMB_OFS) begin
				numb_reg <= {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : numb_reg[15:8],
					WB_SEL_IN[0] ? WB_DAT_IN[7:0] : numb_reg[7:0]};
			end else if (WB_ADR_IN == `DENA_OFS) begin
				dena_reg <= {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : dena_reg[15:8],
					WB_SEL_IN[0] ? WB_DAT_IN[7:0] : dena_reg[7:0]};
			end else if (WB_ADR_IN == `DENB_OFS) begin
				denb_reg <= {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : denb_reg[15:8],
					WB_SEL_IN[0] ? WB_DAT_IN[7:0] : denb_reg[7:0]};
			end else if (WB_ADR_IN == `SHLO_OFS) begin
				shlo_reg <= {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : shlo_reg[15:8],
					WB_SEL_IN[0] ? WB_DAT_IN[7:0] : shlo_reg[7:0]};
			end else if (WB_ADR_IN == `SHHI_OFS) begin
				shhi_reg <= {WB_SEL_IN[1] ? WB_DAT_IN[15:8] : shhi_reg[15:8],
					WB_SEL_IN[0] ? WB_DAT_IN[7:0] : shhi_reg[7:0]};
			end else if (WB_ADR_IN == `REV_OFS) begin
				rev_reg <= {WB_SEL_IN[3] ? WB_DAT_IN[31:24] : rev_reg[31:24],
					WB_SEL_IN[2] ? WB_DAT_IN[23:16] : rev_reg[23:16],
					WB_SEL_IN[1] ? WB_DAT_IN[15:8] : rev_reg[15:8],
					WB_SEL_IN[0] ? WB_DAT_IN[7:0] : rev_reg[7:0]};
			end else if (WB_ADR_IN == `MASK_OFS) begin
				if (WB_SEL_IN[0]) begin
					mask_reg <= WB_DAT_IN[2:0];
				end
			end
		end
	end

	// control mode from filter setting
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			DUAL_FB_OUT <= 1'b0;
			FULL_CLOSED_OUT <= 1'b0;
		end else begin
			DUAL_FB_OUT <= (filt_reg >= `FILT_MIN) && (filt_reg <= `FILT_DUAL_MAX); // R3
			FULL_CLOSED_OUT <= (filt_reg == `FILT_FULL); // R3
		end
	end

	// load counters run whatever the motor does
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			lcum_reg <= 32'h00000000;
			lpos_reg <= 32'h00000000;
		end else begin
			if (l_up && !l_dn) begin
				lcum_reg <= lcum_reg + 32'h00000001; // R2
			end else if (l_dn && !l_up) begin
				lcum_reg <= lcum_reg - 32'h00000001; // R2
			end
			// mark wins over a step in the same cycle
			if (l_ref) begin
				lpos_reg <= 32'h00000000; // R1
			end else if (l_up && !l_dn) begin
				lpos_reg <= lpos_reg + 32'h00000001;
			end else if (l_dn && !l_up) begin
				lpos_reg <= lpos_reg - 32'h00000001;
			end
		end
	end

	// motor count and geared copy; one carry per clock, enough for pulse rates
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			mcum_reg <= 32'h00000000;
			mgear_reg <= 32'h00000000;
			resid_reg <= 48'sh000000000000;
		end else begin
			if (m_up && !m_dn) begin
				mcum_reg <= mcum_reg + 32'h00000001;
				resid_reg <= resid_reg + $signed({16'h0000, gnum}); // R14
			end else if (m_dn && !m_up) begin
				mcum_reg <= mcum_reg - 32'h00000001;
				resid_reg <= resid_reg - $signed({16'h0000, gnum}); // R14
			end else if (resid_reg >= $signed({16'h0000, gden})) begin
				resid_reg <= resid_reg - $signed({16'h0000, gden});
				mgear_reg <= mgear_reg + 32'h00000001; // R14
			end else if (resid_reg <= -$signed({16'h0000, gden})) begin
				resid_reg <= resid_reg + $signed({16'h0000, gden});
				mgear_reg <= mgear_reg - 32'h00000001; // R14
			end
		end
	end

	// position inside a motor revolution, on load data only
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			phase_reg <= 32'h00000000; // absolute zero is a grid point
		end else if (l_ref && HOMING_OUT && !ref_seen_reg && enc_type != `ENC_ABS) begin
			phase_reg <= 32'h00000000; // R10
		end else if (l_up && !l_dn) begin
			phase_reg <= (phase_reg + 32'h00000001 >= rev_reg) ? 32'h00000000 :
				phase_reg + 32'h00000001; // R8
		end else if (l_dn && !l_up) begin
			phase_reg <= (phase_reg == 32'h00000000) ? rev_reg - 32'h00000001 :
				phase_reg - 32'h00000001; // R8
		end
	end

	// homing sequencer; motor z phase is not an input at all
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			state_reg <= S_IDLE;
			ref_seen_reg <= 1'b0;
			hpos_reg <= 32'h00000000;
			HOME_VALID_OUT <= 1'b0;
			ev_set <= 3'h0;
		end else begin
			ev_set <= 3'h0;
			if (l_ref && HOMING_OUT) begin
				ref_seen_reg <= 1'b1;
				ev_set[`ST_REF_BIT] <= 1'b1;
			end
			case (state_reg)
			S_IDLE: begin
				if (start) begin
					ref_seen_reg <= 1'b0;
					HOME_VALID_OUT <= 1'b0;
					if (!WB_DAT_IN[`CTRL_DOG_BIT]) begin
						// data set type, no z needed
						hpos_reg <= lcum_reg + shift; // R12
						HOME_VALID_OUT <= 1'b1;
						ev_set[`ST_DONE_BIT] <= 1'b1;
					end else if (WB_DAT_IN[`CTRL_NOREF_BIT] &&
						WB_DAT_IN[`CTRL_TYPE_LSB+1:`CTRL_TYPE_LSB] == `ENC_INC) begin
						ev_set[`ST_ERR_BIT] <= 1'b1; // R12
					end else begin
						state_reg <= S_DOGON; // R6
					end
				end
			end
			S_DOGON: begin
				if (dog) begin
					state_reg <= S_DOGOFF;
				end
			end
			S_DOGOFF: begin
				// trailing edge of dog ends the search
				if (!dog) begin
					state_reg <= S_IDLE;
					if (enc_type != `ENC_ABS && !ref_seen_reg && !l_ref) begin
						ev_set[`ST_ERR_BIT] <= 1'b1; // R16
					end else begin
						hpos_reg <= grid_pt + shift; // R11
						HOME_VALID_OUT <= 1'b1;
						ev_set[`ST_DONE_BIT] <= 1'b1;
					end
				end
			end
			default: begin
				state_reg <= S_IDLE;
			end
			endcase
		end
	end

	// sticky status, write one clears, a new event wins
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			stat_reg <= 3'h0;
		end else if (wr && WB_ADR_IN == `STAT_OFS && WB_SEL_IN[0]) begin
			stat_reg <= (stat_reg & ~WB_DAT_IN[2:0]) | ev_set;
		end else begin
			stat_reg <= stat_reg | ev_set;
		end
	end
endmodule // fb_home

/* File: tb/fb_home_chk.sv */
// Purpose: port timing relations of the homing block
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ns
module fb_home_chk (
	input wire CLK_IN, // clock
	input wire RST_N_IN, // reset, low active
	input wire WB_CYC_IN, // cycle
	input wire WB_STB_IN, // strobe
	input wire WB_WE_IN, // write
	input wire [7:0] WB_ADR_IN, // address
	input wire [3:0] WB_SEL_IN, // lanes
	input wire [31:0] WB_DAT_IN, // write data
	input wire [31:0] WB_DAT_OUT, // read data
	input wire WB_ACK_OUT, // ack
	input wire LOAD_UP_IN, // load up
	input wire LOAD_DN_IN, // load down
	input wire LOAD_REF_IN, // mark
	input wire MOTOR_UP_IN, // motor up
	input wire MOTOR_DN_IN, // motor down
	input wire DOG_IN, // dog
	input wire DUAL_FB_OUT, // dual mode
	input wire FULL_CLOSED_OUT, // closed mode
	input wire HOMING_OUT, // busy
	input wire HOME_VALID_OUT, // home set
	input wire IRQ_OUT // interrupt
);
	// single domain, so clock and reset given once
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// one wait state on every access
	chk_ack_follows: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("ack late");
	chk_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack held");
	// exactly one mode once the filter is out of reset
	chk_mode_onehot: assert property ($past(RST_N_IN) |-> DUAL_FB_OUT != FULL_CLOSED_OUT)
		else $error("mode pins clash");
	chk_filter_default: assert property ($rose(RST_N_IN) |=> DUAL_FB_OUT)
		else $error("default not dual");
	// home appears as the run ends, not before
	chk_valid_end: assert property ($rose(HOME_VALID_OUT) |-> !HOMING_OUT)
		else $error("home set mid run");
	chk_end_dog_off: assert property ($fell(HOMING_OUT) |-> !DOG_IN && !$past(DOG_IN, 2))
		else $error("run ended with dog on");
	chk_dog_busy: assert property (HOMING_OUT && DOG_IN |=> HOMING_OUT)
		else $error("run ended on dog");
	// interrupt only from a run ending or a register write
	chk_irq_cause: assert property ($rose(IRQ_OUT) |->
		($past(HOMING_OUT, 2) && !$past(HOMING_OUT)) || $past(WB_WE_IN) ||
		$past(WB_WE_IN, 2))
		else $error("irq without cause");
endmodule // fb_home_chk

/* File: tb/enc_model.sv */
// Purpose: encoder and proximity dog pins
// Assumes: block synchronises each pin
// Notes: strobes wide enough that none is lost
`timescale 1ns/1ns
module enc_model (
	input wire clk_in, // clock
	output wire lup_out, // load up
	output wire ldn_out, // load down
	output wire lref_out, // mark
	output wire mup_out, // motor up
	output wire mdn_out, // motor down
	output wire dog_out // dog
);
	logic [4:0] pin_reg = 5'h00; // strobes, low at rest
	logic dog_reg = 1'b0; // dog level
	assign {mdn_out, mup_out, lref_out, ldn_out, lup_out} = pin_reg;
	assign dog_out = dog_reg;
	// three high, three low: the block loses steps closer than two
	task automatic pulse(input integer k);
		integer i;
		for (i = 0; i < 6; i++) begin
			@(posedge clk_in);
			pin_reg[k] <= (i < 3);
		end
	endtask
	// dog change, then time for the sync chain
	task automatic dog(input logic v);
		@(posedge clk_in);
		dog_reg <= v;
		repeat (6) @(posedge clk_in);
	endtask
endmodule // enc_model

/* File: tb/load_side_feedback_homing_bench.sv */
// Purpose: self-checking run of the homing block
// Assumes: pins from enc_model, grid of one reset revolution
// Notes: short strokes only
`timescale 1ns/1ns
`include "fbhome_regs.vh"
module load_side_feedback_homing_bench;
	logic clk, rst_n, cyc, stb, we; // clock, reset, bus
	logic [3:0] sel, wsel; // lanes driven, lanes wanted next
	logic [7:0] adr; // address
	logic [31:0] dat, q, lc; // write, read, expected count
	wire [31:0] dout; // read data
	wire ack, lup, ldn, lref, mup, mdn, dog, dual, full, homing, hvalid, irq; // pins
	integer fail_count, comparisons; // tallies
	fb_home dut (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(dout),
		.WB_ACK_OUT(ack), .LOAD_UP_IN(lup), .LOAD_DN_IN(ldn), .LOAD_REF_IN(lref),
		.MOTOR_UP_IN(mup), .MOTOR_DN_IN(mdn), .DOG_IN(dog), .DUAL_FB_OUT(dual),
		.FULL_CLOSED_OUT(full), .HOMING_OUT(homing), .HOME_VALID_OUT(hvalid), .IRQ_OUT(irq));
	enc_model pm (.clk_in(clk), .lup_out(lup), .ldn_out(ldn), .lref_out(lref),
		.mup_out(mup), .mdn_out(mdn), .dog_out(dog));
	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// verdict and end of run
	task automatic report_and_stop;
		if (fail_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// compare one value
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	// classic cycle held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= wsel;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dout;
		if (n >= 20) begin
			cmp(0, 1, "no ack");
			report_and_stop;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
		cmp(ack, 0, "ack drop");
	endtask
	// read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		wb(1'b0, a, 32'h00000000);
		cmp(q, e, m);
	endtask
	// defaults out of reset
	task automatic t_reset;
		rd(`FILT_OFS, 32'h0000000A, "filter default");
		cmp(dual, 1, "dual default");
		rd(`REV_OFS, `REV_RST, "rev default");
		wb(1'b1, 8'hF0, 32'hFFFFFFFF);
		rd(8'hF0, 0, "unmapped");
	endtask
	// both range ends, then refused values
	task automatic t_filter;
		logic [12:0] v [5];
		logic [12:0] e;
		integer i;
		v = '{13'h1194, 13'h0001, 13'h1193, 13'h0000, 13'h1195};
		e = `FILT_RST;
		for (i = 0; i < 5; i++) begin
			wb(1'b1, `FILT_OFS, {19'h00000, v[i]});
			if (v[i] >= `FILT_MIN && v[i] <= `FILT_FULL) e = v[i];
			rd(`FILT_OFS, {19'h00000, e}, "filter");
			cmp(full, e == `FILT_FULL, "closed pin");
			cmp(dual, e <= `FILT_DUAL_MAX, "dual pin");
		end
		wb(1'b1, `FILT_OFS, `FILT_RST);
	endtask
	// steps move both counts, the mark clears only position
	task automatic t_count;
		integer i;
		for (i = 0; i < 3; i++) pm.pulse(0);
		pm.pulse(1);
		pm.pulse(2);
		pm.pulse(0);
		lc = 3;
		rd(`LCUM_OFS, lc, "load count");
		rd(`LPOS_OFS, 1, "position");
		for (i = 0; i < 4; i++) pm.pulse(3);
		pm.pulse(4);
		rd(`MGEAR_OFS, lc, "geared count");
		rd(`MCUM_OFS, 3, "motor count");
		wsel = 4'h1;
		wb(1'b1, `NUMA_OFS, 32'hFFFF0003);
		wb(1'b1, `FILT_OFS, 32'h00000005);
		wsel = 4'hF;
		rd(`NUMA_OFS, 3, "lane write");
		rd(`FILT_OFS, `FILT_RST, "filter half lanes");
		wb(1'b1, `DENA_OFS, 2);
		for (i = 0; i < 2; i++) pm.pulse(3);
		rd(`MGEAR_OFS, 6, "gear three halves");
	endtask
	// start, dog on, strokes around an optional mark, dog off
	task automatic home(input logic [5:0] c, input integer pre, input integer post,
		input logic mk);
		integer i;
		wb(1'b1, `CTRL_OFS, {26'h0000000, c});
		pm.dog(1'b1);
		for (i = 0; i < pre + post; i++) begin
			if (mk && i == pre) pm.pulse(2);
			pm.pulse(0);
		end
		cmp(homing, 1, "busy on dog");
		pm.dog(1'b0);
		lc = lc + pre + post;
	endtask
	// incremental grid from the mark, shift added, irq on done
	task automatic t_home_inc;
		wb(1'b1, `SHLO_OFS, 2);
		wb(1'b1, `MASK_OFS, 3);
		home(6'h0B, 2, 5, 1'b1);
		rd(`HPOS_OFS, lc - 5 + `REV_RST + 2, "inc home");
		cmp(hvalid, 1, "valid");
		rd(`STAT_OFS, 32'h00000005, "done");
		cmp(irq, 1, "irq set");
		wb(1'b1, `STAT_OFS, 32'h00000007);
		cmp(irq, 0, "irq clear");
	endtask
	// rotary without mark, then a no-mark setup refusing z homing
	task automatic t_home_err;
		home(6'h0D, 2, 0, 1'b0);
		cmp(hvalid, 0, "no valid");
		rd(`STAT_OFS, 32'h00000002, "error");
		cmp(irq, 1, "irq error");
		wb(1'b1, `STAT_OFS, 32'h00000007);
		wb(1'b1, `CTRL_OFS, 32'h0000001B);
		repeat (4) @(posedge clk);
		rd(`STAT_OFS, 32'h00000002, "noref");
		wb(1'b1, `STAT_OFS, 32'h00000007);
	endtask
	// absolute grid from zero, forward and back, done masked
	task automatic t_home_abs;
		wb(1'b1, `SHLO_OFS, 2);
		wb(1'b1, `MASK_OFS, 2);
		home(6'h09, 3, 0, 1'b0);
		rd(`HPOS_OFS, lc + ((`REV_RST - lc % `REV_RST) % `REV_RST) + 2, "abs fwd");
		cmp(irq, 0, "masked");
		home(6'h29, 1, 0, 1'b0);
		rd(`HPOS_OFS, lc - lc % `REV_RST + 2, "abs back");
		wb(1'b1, `STAT_OFS, 32'h00000007);
	endtask
	// data-set homing needs neither dog nor mark
	task automatic t_home_set;
		wb(1'b1, `CTRL_OFS, 32'h00000001);
		cmp(homing, 0, "set not busy");
		cmp(hvalid, 1, "set valid");
		rd(`HPOS_OFS, lc + 2, "set home");
		rd(`STAT_OFS, 32'h00000001, "set done");
		cmp(irq, 1, "irq set done");
	endtask
	// reset, then scenarios
	initial begin
		fail_count = 0;
		comparisons = 0;
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		wsel = 4'hF;
		adr = 8'h00;
		dat = 32'h00000000;
		lc = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_filter;
		t_count;
		t_home_abs;
		t_home_inc;
		t_home_err;
		t_home_set;
		report_and_stop;
	end
	// watchdog, well past the expected few hundred cycles
	initial begin
		#300000;
		fail_count++;
		report_and_stop;
	end
endmodule // load_side_feedback_homing_bench
bind fb_home fb_home_chk chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
	.WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
	.LOAD_UP_IN(LOAD_UP_IN), .LOAD_DN_IN(LOAD_DN_IN), .LOAD_REF_IN(LOAD_REF_IN),
	.MOTOR_UP_IN(MOTOR_UP_IN), .MOTOR_DN_IN(MOTOR_DN_IN), .DOG_IN(DOG_IN),
	.DUAL_FB_OUT(DUAL_FB_OUT), .FULL_CLOSED_OUT(FULL_CLOSED_OUT), .HOMING_OUT(HOMING_OUT),
	.HOME_VALID_OUT(HOME_VALID_OUT), .IRQ_OUT(IRQ_OUT));
